// ---- cpc_pkg.sv ----
// Purpose: Shared constants and types for the perf counter control block
// Assumes: APB slave, 32-bit data, one clock
// Notes: Offsets are byte addresses
package cpc_pkg;
  localparam logic [11:0] CPC_TRACE_STATUS_OFS = 12'h820;
  localparam logic [11:0] CPC_TRACE_CFG_OFS = 12'h830;
  localparam logic [11:0] CPC_CONTROL_OFS = 12'h900;
  localparam logic [11:0] CPC_OVF_OFS = 12'h920;
  localparam logic [11:0] CPC_EVSEL_OFS = 12'h930;
  localparam logic [11:0] CPC_CYCLES_OFS = 12'h980;
  localparam logic [11:0] CPC_EVCNT0_OFS = 12'h998;
  localparam logic [11:0] CPC_EVCNT1_OFS = 12'h9a8;
  localparam logic [11:0] CPC_IRQ_MASK_OFS = 12'h940;
  localparam int CPC_IDLE_BIT = 8;
  localparam int CPC_PRESENT_BIT = 0;
  localparam int CPC_TEN_BIT = 0;
  localparam int CPC_DLY_LSB = 1;
  localparam int CPC_DLY_W = 10;
  localparam int CPC_INT_EN_BIT = 30;
  localparam int CPC_STOP_BIT = 29;
  localparam int CPC_E1_CLR_BIT = 9;
  localparam int CPC_E1_RUN_BIT = 8;
  localparam int CPC_E0_CLR_BIT = 7;
  localparam int CPC_E0_RUN_BIT = 6;
  localparam int CPC_CY_CLR_BIT = 5;
  localparam int CPC_CY_RUN_BIT = 4;
  localparam logic [3:0] CPC_NUM_EVCNT = 4'h2;
  localparam logic [2:0] CPC_OVF_RST = 3'h0;
  localparam logic [31:0] CPC_ALL_ONES = 32'hffffffff;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } cpc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cpc_apb_rsp_t;

  typedef struct packed {
    logic trc_en;
    logic [9:0] delay;
    logic int_en;
    logic stop;
    logic e1_run;
    logic e0_run;
    logic cy_run;
    logic [2:0] ovf;
    logic [2:0] mask;
    logic [15:0] evsel;
    logic [31:0] cyc;
    logic [31:0] ev0;
    logic [31:0] ev1;
    logic [31:0] rdata;
    logic slverr;
  } cpc_state_t;
endpackage

// ---- cpc_ctl.sv ----
// Purpose: Perf counter and trace status control registers on APB
// Assumes: Event pulses synchronous to pclk
// Notes: Operation rules below
// Operation
// RL1 - Status bit 8 shows trace unit idle, reset value one
// RL2 - Status bit 0 reads one; bits 31:9 and 7:1 read zero
// RL3 - Config bits 10:1 hold snapshot delay, reset from build parameter
// RL4 - Config bit 0 enables counter trace messages; upper bits read zero
// RL5 - Trace status and config words exist only with trace option
// RL6 - Interrupt bit 30 lets any enabled overflow raise the interrupt
// RL7 - Stop bit 29 clears all run bits on enabled overflow
// RL8 - Clear bit 9 with run bit 8 zeroes counter 1 and flag
// RL9 - Clear bit 7 with run bit 6 zeroes counter 0 and flag
// RL10 - Clear bit 5 with run bit 4 zeroes cycle counter and flag
// RL11 - Clear bits self-return to zero and always read zero
// RL12 - Event counter 1 counts while bit 8 set, holds otherwise
// RL13 - Event counter 0 counts while bit 6 set, holds otherwise
// RL14 - Cycle counter advances while bit 4 set, holds otherwise
// RL15 - Run bits self-clear on overflow with stop enabled
// RL16 - Bits 3:0 read two; bits 31 and 28:10 read zero
// RL17 - Sticky overflow flags at bits 2:0, write one to clear
// RL18 - Cycle counter is 32 bits, readable and writable
// RL19 - Counters wrap from all ones to zero setting overflow flag
`timescale 1ns/1ps
module cpc_ctl
  import cpc_pkg::*;
#(
  parameter bit TRACE_PRESENT = 1'b1,
  parameter logic [9:0] DELAY_RESET = 10'h000,
  parameter bit TRACE_EN_RESET = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB
  input wire cpc_pkg::cpc_apb_req_t apb_req,
  output cpc_pkg::cpc_apb_rsp_t apb_rsp,
  // Events and trace unit
  input wire logic event0_pulse,
  input wire logic event1_pulse,
  input wire logic trace_unit_idle,
  output logic counter_trace_enable,
  output logic [9:0] snapshot_delay,
  output logic [15:0] event_select,
  output logic perf_irq
);
  import cpc_pkg::*;

  cpc_state_t s_q;
  cpc_state_t s_d;
  logic wr;
  logic rd;
  logic [11:0] a;
  logic [31:0] wd;
  logic [2:0] wrap;
  logic [2:0] runv;
  logic ovf_evt;
  logic [31:0] status_w;
  logic [31:0] cfg_w;
  logic [31:0] ctl_w;
  logic hit;
  logic wr_ctl;
  logic wr_ovf;
  logic wr_cfg;
  logic rd_ok;

  // Qualified strobes for the checks below
  assign wr_ctl = wr && (a == CPC_CONTROL_OFS);
  assign wr_ovf = wr && (a == CPC_OVF_OFS);
  assign wr_cfg = wr && (a == CPC_TRACE_CFG_OFS);
  assign rd_ok = rd && clk_en;

  assign a = apb_req.paddr[11:0];
  assign wd = apb_req.pwdata;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && clk_en;
  assign rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign runv = {s_q.e1_run, s_q.e0_run, s_q.cy_run};
  // Increment from all ones wraps and flags overflow
  assign wrap[0] = s_q.cy_run && (s_q.cyc == CPC_ALL_ONES); // RL19
  assign wrap[1] = s_q.e0_run && event0_pulse && (s_q.ev0 == CPC_ALL_ONES);
  assign wrap[2] = s_q.e1_run && event1_pulse && (s_q.ev1 == CPC_ALL_ONES);
  assign ovf_evt = |wrap;

  always_comb begin
    status_w = '0;
    status_w[CPC_IDLE_BIT] = trace_unit_idle; // RL1
    status_w[CPC_PRESENT_BIT] = 1'b1; // RL2
    cfg_w = '0;
    cfg_w[CPC_TEN_BIT] = s_q.trc_en; // RL4
    cfg_w[CPC_DLY_LSB +: CPC_DLY_W] = s_q.delay; // RL3
    ctl_w = '0;
    ctl_w[CPC_INT_EN_BIT] = s_q.int_en;
    ctl_w[CPC_STOP_BIT] = s_q.stop;
    ctl_w[CPC_E1_RUN_BIT] = s_q.e1_run;
    ctl_w[CPC_E0_RUN_BIT] = s_q.e0_run;
    ctl_w[CPC_CY_RUN_BIT] = s_q.cy_run;
    ctl_w[3:0] = CPC_NUM_EVCNT; // RL16 RL11
  end

  always_comb begin
    hit = 1'b1;
    unique case (a)
      CPC_TRACE_STATUS_OFS, CPC_TRACE_CFG_OFS: hit = TRACE_PRESENT; // RL5
      CPC_CONTROL_OFS, CPC_OVF_OFS, CPC_EVSEL_OFS, CPC_CYCLES_OFS,
      CPC_EVCNT0_OFS, CPC_EVCNT1_OFS, CPC_IRQ_MASK_OFS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    // Counting
    if (s_q.cy_run) begin
      s_d.cyc = s_q.cyc + 32'h1; // RL14 RL18
    end
    if (s_q.e0_run && event0_pulse) begin
      s_d.ev0 = s_q.ev0 + 32'h1; // RL13
    end
    if (s_q.e1_run && event1_pulse) begin
      s_d.ev1 = s_q.ev1 + 32'h1; // RL12
    end
    // Register reads captured in setup phase
    if (rd) begin
      s_d.slverr = !hit;
      unique case (a)
        CPC_TRACE_STATUS_OFS: s_d.rdata = TRACE_PRESENT ? status_w : '0;
        CPC_TRACE_CFG_OFS: s_d.rdata = TRACE_PRESENT ? cfg_w : '0;
        CPC_CONTROL_OFS: s_d.rdata = ctl_w;
        CPC_OVF_OFS: s_d.rdata = {29'h0, s_q.ovf};
        CPC_IRQ_MASK_OFS: s_d.rdata = {29'h0, s_q.mask};
        CPC_EVSEL_OFS: s_d.rdata = {16'h0, s_q.evsel};
        CPC_CYCLES_OFS: s_d.rdata = s_q.cyc;
        CPC_EVCNT0_OFS: s_d.rdata = s_q.ev0;
        CPC_EVCNT1_OFS: s_d.rdata = s_q.ev1;
        default: s_d.rdata = '0;
      endcase
    end else if (apb_req.psel && !apb_req.penable) begin
      s_d.slverr = !hit;
      s_d.rdata = '0;
    end
    // Register writes
    if (wr) begin
      unique case (a)
        CPC_TRACE_CFG_OFS: begin
          if (TRACE_PRESENT) begin
            s_d.trc_en = wd[CPC_TEN_BIT]; // RL4
            s_d.delay = wd[CPC_DLY_LSB +: CPC_DLY_W]; // RL3
          end
        end
        CPC_CONTROL_OFS: begin
          s_d.int_en = wd[CPC_INT_EN_BIT]; // RL6
          s_d.stop = wd[CPC_STOP_BIT]; // RL7
          s_d.e1_run = wd[CPC_E1_RUN_BIT];
          s_d.e0_run = wd[CPC_E0_RUN_BIT];
          s_d.cy_run = wd[CPC_CY_RUN_BIT];
          if (wd[CPC_E1_CLR_BIT] && wd[CPC_E1_RUN_BIT]) begin
            s_d.ev1 = '0; // RL8
            s_d.ovf[2] = 1'b0;
          end
          if (wd[CPC_E0_CLR_BIT] && wd[CPC_E0_RUN_BIT]) begin
            s_d.ev0 = '0; // RL9
            s_d.ovf[1] = 1'b0;
          end
          if (wd[CPC_CY_CLR_BIT] && wd[CPC_CY_RUN_BIT]) begin
            s_d.cyc = '0; // RL10
            s_d.ovf[0] = 1'b0;
          end
        end
        CPC_OVF_OFS: s_d.ovf = s_d.ovf & ~wd[2:0]; // RL17
        CPC_IRQ_MASK_OFS: s_d.mask = wd[2:0];
        CPC_EVSEL_OFS: s_d.evsel = wd[15:0];
        CPC_CYCLES_OFS: s_d.cyc = wd; // RL18
        CPC_EVCNT0_OFS: s_d.ev0 = wd;
        CPC_EVCNT1_OFS: s_d.ev1 = wd;
        default: s_d.rdata = s_d.rdata;
      endcase
    end
    // Overflow set wins over software clear
    s_d.ovf = s_d.ovf | wrap; // RL17 RL19
    if (ovf_evt && s_q.stop) begin
      s_d.e1_run = 1'b0; // RL7 RL15
      s_d.e0_run = 1'b0;
      s_d.cy_run = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{trc_en: TRACE_EN_RESET, delay: DELAY_RESET, int_en: 1'b0,
               stop: 1'b0, e1_run: 1'b0, e0_run: 1'b0, cy_run: 1'b0,
               ovf: CPC_OVF_RST, mask: 3'h7, evsel: 16'h0, cyc: 32'h0,
               ev0: 32'h0, ev1: 32'h0, rdata: 32'h0, slverr: 1'b0};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign apb_rsp.prdata = s_q.rdata;
  assign apb_rsp.pready = apb_req.psel && apb_req.penable && clk_en;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && s_q.slverr;
  assign counter_trace_enable = TRACE_PRESENT && s_q.trc_en; // RL4
  assign snapshot_delay = TRACE_PRESENT ? s_q.delay : '0;
  assign event_select = s_q.evsel;
  assign perf_irq = s_q.int_en && |(s_q.ovf & s_q.mask); // RL6

  // Assertions
  property p_stop;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && ovf_evt && s_q.stop) |=> (runv == 3'h0);
  endproperty
  stop_on_ovf_a: assert property (p_stop) // RL7
    else $error("run bits not cleared on overflow stop");
  sticky_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && wrap[0]) |=> s_q.ovf[0]) // RL17
    else $error("cycle overflow flag not set");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !s_q.int_en |-> !perf_irq) // RL6
    else $error("interrupt raised while disabled");
  cyc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && !s_q.cy_run && !wr) |=> $stable(s_q.cyc)) // RL14
    else $error("cycle counter moved while stopped");
  cyc_step_a: assert property (@(posedge pclk) disable iff (!presetn) // RL18
      (clk_en && s_q.cy_run && !wr) |=> (s_q.cyc == $past(s_q.cyc) + 32'h1))
    else $error("cycle counter did not step");
  wrap_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && wrap[1] && !wr) |=> (s_q.ev0 == 32'h0)) // RL19
    else $error("event counter 0 did not wrap");
  clr1_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && a == CPC_CONTROL_OFS && wd[9] && wd[8] && !wrap[2]) |=>
      (s_q.ev1 == 32'h0 && !s_q.ovf[2])) // RL8
    else $error("counter 1 not cleared");
  num_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
      ctl_w[3:0] == 4'h2 && ctl_w[31] == 1'b0) // RL16
    else $error("control constant field wrong");

  // Multi-step behaviours
  sequence s_ovf_stop;
    clk_en && ovf_evt && s_q.stop;
  endsequence

  sequence s_quiet;
    clk_en && !wr;
  endsequence

  sequence s_clr0_wr;
    wr_ctl && wd[CPC_E0_CLR_BIT] && wd[CPC_E0_RUN_BIT] && !wrap[1] &&
    !(ovf_evt && s_q.stop);
  endsequence

  sequence s_ev0_tick;
    clk_en && event0_pulse && !wr;
  endsequence

  sequence s_clrc_wr;
    wr_ctl && wd[CPC_CY_CLR_BIT] && wd[CPC_CY_RUN_BIT] && !wrap[0] &&
    !(ovf_evt && s_q.stop);
  endsequence

  stop_stays_a: assert property (@(posedge pclk) disable iff (!presetn) // RL15
      s_ovf_stop ##1 s_quiet |=> (runv == 3'h0))
    else $error("counters restarted after overflow stop");

  clr0_count_a: assert property (@(posedge pclk) disable iff (!presetn) // RL9
      s_clr0_wr ##1 s_ev0_tick |=> (s_q.ev0 == 32'h1))
    else $error("counter 0 did not count from zero");

  clrc_count_a: assert property (@(posedge pclk) disable iff (!presetn) // RL10
      s_clrc_wr ##1 s_quiet |=> (s_q.cyc == 32'h1))
    else $error("cycle counter did not count from zero");

  status_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // RL1
      (rd_ok && a == CPC_TRACE_STATUS_OFS && TRACE_PRESENT) |=>
      (s_q.rdata[CPC_IDLE_BIT] == $past(trace_unit_idle)))
    else $error("idle bit not reported");

  status_impl_a: assert property (@(posedge pclk) disable iff (!presetn) // RL2
      (rd_ok && a == CPC_TRACE_STATUS_OFS && TRACE_PRESENT) |=>
      (s_q.rdata[0] && s_q.rdata[31:9] == 23'h0 && s_q.rdata[7:1] == 7'h0))
    else $error("status word fields wrong");

  cfg_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn) // RL4
      (rd_ok && a == CPC_TRACE_CFG_OFS) |=> (s_q.rdata[31:11] == 21'h0))
    else $error("config reserved bits not zero");

  cfg_delay_a: assert property (@(posedge pclk) disable iff (!presetn) // RL3
      (wr_cfg && TRACE_PRESENT) |=> (snapshot_delay == $past(wd[10:1])))
    else $error("snapshot delay not written");

  cfg_enable_a: assert property (@(posedge pclk) disable iff (!presetn) // RL4
      (wr_cfg && TRACE_PRESENT) |=> (counter_trace_enable == $past(wd[0])))
    else $error("trace enable not written");

  trace_absent_a: assert property (@(posedge pclk) disable iff (!presetn) // RL5
      (rd_ok && !TRACE_PRESENT &&
      (a == CPC_TRACE_STATUS_OFS || a == CPC_TRACE_CFG_OFS)) |=>
      (s_q.slverr && s_q.rdata == 32'h0))
    else $error("absent trace word answered");

  irq_on_a: assert property (@(posedge pclk) disable iff (!presetn) // RL6
      (s_q.int_en && |(s_q.ovf & s_q.mask)) |-> perf_irq)
    else $error("interrupt missing on overflow");

  clr0_a: assert property (@(posedge pclk) disable iff (!presetn) // RL9
      s_clr0_wr |=> (s_q.ev0 == 32'h0 && !s_q.ovf[1]))
    else $error("counter 0 not cleared");

  clrc_a: assert property (@(posedge pclk) disable iff (!presetn) // RL10
      s_clrc_wr |=> (s_q.cyc == 32'h0 && !s_q.ovf[0]))
    else $error("cycle counter not cleared");

  resume0_a: assert property (@(posedge pclk) disable iff (!presetn) // RL9
      (wr_ctl && wd[CPC_E0_RUN_BIT] && !wd[CPC_E0_CLR_BIT] &&
      !s_q.e0_run) |=> (s_q.ev0 == $past(s_q.ev0)))
    else $error("counter 0 lost value on resume");

  clr_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RL11
      (rd_ok && a == CPC_CONTROL_OFS) |=>
      (!s_q.rdata[9] && !s_q.rdata[7] && !s_q.rdata[5]))
    else $error("clear bit read back as one");

  ev1_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL12
      (clk_en && !s_q.e1_run && !wr) |=> $stable(s_q.ev1))
    else $error("counter 1 moved while stopped");

  ev1_step_a: assert property (@(posedge pclk) disable iff (!presetn) // RL12
      (clk_en && s_q.e1_run && event1_pulse && !wr) |=>
      (s_q.ev1 == $past(s_q.ev1) + 32'h1))
    else $error("counter 1 did not step");

  ev0_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL13
      (clk_en && !s_q.e0_run && !wr) |=> $stable(s_q.ev0))
    else $error("counter 0 moved while stopped");

  ev0_step_a: assert property (@(posedge pclk) disable iff (!presetn) // RL13
      (clk_en && s_q.e0_run && event0_pulse && !wr) |=>
      (s_q.ev0 == $past(s_q.ev0) + 32'h1))
    else $error("counter 0 did not step");

  ctl_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RL16
      (rd_ok && a == CPC_CONTROL_OFS) |=>
      (s_q.rdata[3:0] == 4'h2 && !s_q.rdata[31] &&
      s_q.rdata[28:10] == 19'h0))
    else $error("control read fields wrong");

  sticky_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL17
      (clk_en && s_q.ovf[0] && !(wr_ovf && wd[0]) &&
      !(wr_ctl && wd[CPC_CY_CLR_BIT] && wd[CPC_CY_RUN_BIT])) |=>
      s_q.ovf[0])
    else $error("cycle overflow flag lost");

  w1c_a: assert property (@(posedge pclk) disable iff (!presetn) // RL17
      (wr_ovf && wd[0] && !wrap[0]) |=> !s_q.ovf[0])
    else $error("overflow flag not cleared by one");

  ev0_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RL17
      (clk_en && wrap[1]) |=> s_q.ovf[1])
    else $error("counter 0 overflow flag not set");

  ev1_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // RL19
      (clk_en && wrap[2] && !wr) |=> (s_q.ev1 == 32'h0 && s_q.ovf[2]))
    else $error("counter 1 did not wrap");

  cyc_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RL18
      (wr && a == CPC_CYCLES_OFS) |=> (s_q.cyc == $past(wd)))
    else $error("cycle counter write lost");

  cyc_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RL18
      (rd_ok && a == CPC_CYCLES_OFS) |=> (s_q.rdata == $past(s_q.cyc)))
    else $error("cycle counter read wrong");

  freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
      !clk_en |=> $stable(s_q))
    else $error("state moved with clock enable low");

  no_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      !clk_en |-> !apb_rsp.pready)
    else $error("ready raised while frozen");
endmodule // cpc_ctl

// ---- tb_coherence_perf_counter_ctl.sv ----
// Purpose: Self-checking bench for the perf counter control block
// Assumes: APB master in the bench, clk_en held high
// Notes: Counter values are checked through register reads
`timescale 1ns/1ps
module tb_coherence_perf_counter_ctl;
  import cpc_pkg::*;
  logic pclk, presetn, ev0, ev1, idle, trc_en, irq, err;
  logic [9:0] dly;
  logic [31:0] rd;
  cpc_apb_req_t req;
  cpc_apb_rsp_t rsp;
  int miscompares = 0;
  int check_count = 0;
  cpc_ctl #(.DELAY_RESET(10'h005), .TRACE_EN_RESET(1'b1)) DUT (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .apb_req(req),
    .apb_rsp(rsp), .event0_pulse(ev0), .event1_pulse(ev1),
    .trace_unit_idle(idle), .counter_trace_enable(trc_en),
    .snapshot_delay(dly), .event_select(), .perf_irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req.paddr <= {20'h0, a};
    req.pwrite <= w;
    req.pwdata <= d;
    req.pstrb <= 4'hf;
    req.psel <= 1'b1;
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic t_reset;
    chk({21'h0, dly, trc_en}, 32'h0000000b);
    rdchk(CPC_TRACE_STATUS_OFS, 32'h00000101);
    rdchk(CPC_TRACE_CFG_OFS, 32'h0000000b);
    rdchk(CPC_CONTROL_OFS, 32'h00000002);
    rdchk(CPC_OVF_OFS, 32'h0);
  endtask
  task automatic t_fields;
    xfer(1'b1, CPC_TRACE_STATUS_OFS, 32'hffffffff);
    rdchk(CPC_TRACE_STATUS_OFS, 32'h00000101);
    xfer(1'b1, CPC_TRACE_CFG_OFS, 32'hffffffff);
    rdchk(CPC_TRACE_CFG_OFS, 32'h000007ff);
    chk({21'h0, dly, trc_en}, 32'h000007ff);
    xfer(1'b1, CPC_CONTROL_OFS, 32'hffffffff);
    rdchk(CPC_CONTROL_OFS, 32'h60000152);
    xfer(1'b1, CPC_CONTROL_OFS, 32'h0);
    idle <= 1'b0;
    rdchk(CPC_TRACE_STATUS_OFS, 32'h00000001);
    idle <= 1'b1;
    xfer(1'b1, CPC_EVSEL_OFS, 32'hffffffff);
    rdchk(CPC_EVSEL_OFS, 32'h0000ffff);
    xfer(1'b0, 12'h004, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
  endtask
  task automatic t_events;
    xfer(1'b1, CPC_EVCNT0_OFS, 32'h5);
    xfer(1'b1, CPC_EVCNT1_OFS, 32'ha);
    xfer(1'b1, CPC_CONTROL_OFS, 32'h000001c0);
    ev0 <= 1'b1;
    ev1 <= 1'b1;
    repeat (3) @(posedge pclk);
    ev0 <= 1'b0;
    ev1 <= 1'b0;
    xfer(1'b1, CPC_CONTROL_OFS, 32'h0);
    rdchk(CPC_EVCNT0_OFS, 32'h3);
    rdchk(CPC_EVCNT1_OFS, 32'hd);
    ev0 <= 1'b1;
    repeat (2) @(posedge pclk);
    ev0 <= 1'b0;
    rdchk(CPC_EVCNT0_OFS, 32'h3);
    xfer(1'b1, CPC_CONTROL_OFS, 32'h00000330);
    xfer(1'b1, CPC_CONTROL_OFS, 32'h0);
    rdchk(CPC_EVCNT1_OFS, 32'h0);
    rdchk(CPC_CYCLES_OFS, 32'h3);
  endtask
  task automatic t_overflow;
    xfer(1'b1, CPC_CYCLES_OFS, 32'hfffffffe);
    xfer(1'b1, CPC_CONTROL_OFS, 32'h00000010);
    repeat (4) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rdchk(CPC_CONTROL_OFS, 32'h00000012);
    rdchk(CPC_OVF_OFS, 32'h1);
    xfer(1'b1, CPC_OVF_OFS, 32'h1);
    xfer(1'b1, CPC_CONTROL_OFS, 32'h60000000);
    xfer(1'b1, CPC_CYCLES_OFS, 32'hfffffffe);
    xfer(1'b1, CPC_CONTROL_OFS, 32'h60000010);
    repeat (4) @(posedge pclk);
    rdchk(CPC_CONTROL_OFS, 32'h60000002);
    rdchk(CPC_CYCLES_OFS, 32'h0);
    rdchk(CPC_OVF_OFS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, CPC_IRQ_MASK_OFS, 32'h0);
    #1;
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, CPC_IRQ_MASK_OFS, 32'h7);
    xfer(1'b1, CPC_OVF_OFS, 32'h1);
    #1;
    chk({31'h0, irq}, 32'h0);
    rdchk(CPC_OVF_OFS, 32'h0);
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    presetn = 1'b0;
    req = '0;
    ev0 = 1'b0;
    ev1 = 1'b0;
    idle = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_fields;
    t_events;
    t_overflow;
    tally_and_finish;
  end
endmodule // tb_coherence_perf_counter_ctl
